// [rtl/mbw_regs.vh]
`ifndef MBW_REGS_VH
`define MBW_REGS_VH
`define MBW_CTRL_ADDR 32'h01C80000
`define MBW_MODE_ADDR 32'h01C80040
`define MBW_CTRL_RESET 32'h00000000
`define MBW_MODE_RESET 10'h000
`define MBW_ORDER_BIT 0
`define MBW_BOOT_LSB 1
`define MBW_SPARE_BIT 3
`define MBW_BANK_STEP 4
`define MBW_WIDTH_LSB 0
`define MBW_WAIT_BIT 2
`define MBW_STYLE_BIT 3
`define MBW_W8 2'h0
`define MBW_W16 2'h1
`define MBW_W32 2'h2
`define MBW_TEST 2'h3
`define MBW_SIZE_LSB 0
`define MBW_ORG_BIT 4
`define MBW_B6DYN_BIT 8
`define MBW_B7DYN_BIT 9
`define MBW_SZ2 3'h0
`define MBW_SZ4 3'h1
`define MBW_SZ8 3'h2
`define MBW_SZ16 3'h3
`define MBW_SZ32 3'h4
`define MBW_RESP_OKAY 2'h0
`define MBW_RESP_SLVERR 2'h2
`endif

// [rtl/mbw_addr_map.v]
`timescale 1ns/100ps
`default_nettype none
`include "mbw_regs.vh"
// shifts internal address onto memory pins and picks the sdram bank select
module mbw_addr_map
(
  input wire [1:0] width_i,
  input wire [2:0] size_i,
  input wire four_bank_i,
  input wire [25:0] addr_i,
  output reg [25:0] mem_addr_o,
  output reg [1:0] sdram_bank_o
);
  always @*
  begin
    case (width_i)
      `MBW_W16: mem_addr_o = {1'b0, addr_i[25:1]};
      `MBW_W32: mem_addr_o = {2'h0, addr_i[25:2]};
      default: mem_addr_o = addr_i;
    endcase
  end

  always @*
  begin
    sdram_bank_o = 2'h0;
    if (four_bank_i)
    begin
      // two-bank sizes have no four-bank parts; fall back to zero
      case (size_i)
        `MBW_SZ8: sdram_bank_o = addr_i[22:21];
        `MBW_SZ16: sdram_bank_o = addr_i[23:22];
        `MBW_SZ32: sdram_bank_o = addr_i[24:23];
        default: sdram_bank_o = 2'h0;
      endcase
    end
    else
    begin
      case (size_i)
        `MBW_SZ2: sdram_bank_o = {1'b0, addr_i[20]};
        `MBW_SZ4: sdram_bank_o = {1'b0, addr_i[21]};
        `MBW_SZ8: sdram_bank_o = {1'b0, addr_i[22]};
        `MBW_SZ16: sdram_bank_o = {1'b0, addr_i[23]};
        `MBW_SZ32: sdram_bank_o = {1'b0, addr_i[24]};
        default: sdram_bank_o = 2'h0;
      endcase
    end
  end
endmodule // mbw_addr_map
`default_nettype wire

// [rtl/mbw_top.v]
`timescale 1ns/100ps
`default_nettype none
`include "mbw_regs.vh"
// What this block does
// - memory address pins shift down by 0, 1 or 2 for 8/16/32-bit banks.
// - two-bank sdram bank select is address bit 20..24 by bank size.
// - four-bank sdram bank selects are bits 22:21, 23:22 or 24:23 by size.
// - lane style for banks one to seven picks write strobes or upper/lower byte enables; bank zero uses write strobes.
// - wait enable for banks one to seven lets external wait stretch that bank's cycle; bank zero never waits.
// - banks six and seven ignore wait when holding dram or sdram.
// - two-bit width per bank: 00 8-bit, 01 16-bit, 10 32-bit.
// - bits 2:1 read back boot bank width from boot width pins.
// - bit 0 reads back byte order, 0 meaning little-endian.
// - reset clears all writable fields of the width and wait register.
// - boot width pins sampled during reset; 11 means test mode.
// - byte order pin latched while reset is held.
// - each byte enable is write strobe AND output enable, active low.
module mbw_top
(
  input wire clk_i,
  input wire reset_i,
  input wire [31:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [31:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [1:0] boot_width_select_i,
  input wire byte_order_i,
  output wire test_mode_o,
  input wire [2:0] access_bank_i,
  input wire [25:0] access_addr_i,
  input wire [3:0] write_lanes_n_i,
  input wire read_strobe_n_i,
  input wire ext_wait_i,
  output reg [25:0] mem_addr_o,
  output reg [1:0] sdram_bank_o,
  output wire [1:0] access_width_o,
  output wire wait_stretch_o,
  output reg [3:0] write_byte_strobe_n_o,
  output reg [3:0] byte_lane_enable_n_o,
  output reg output_enable_n_o
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [31:0] ctrl;
  reg [9:0] mode;
  reg [1:0] boot_width_meta;
  reg [1:0] boot_width_sync;
  reg byte_order_meta;
  reg byte_order_sync;
  reg [1:0] boot_bank_width;
  reg byte_order;
  reg [1:0] ext_wait_sync;

  // pins pass two flops before anyone looks at them
  always @(posedge clk_i)
  begin
    boot_width_meta <= boot_width_select_i;
    boot_width_sync <= boot_width_meta;
    byte_order_meta <= byte_order_i;
    byte_order_sync <= byte_order_meta;
    ext_wait_sync <= {ext_wait_sync[0], ext_wait_i};
  end

  // straps keep tracking through reset and freeze on release
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      boot_bank_width <= boot_width_sync;
      byte_order <= byte_order_sync;
    end
  end

  assign test_mode_o = (boot_bank_width == `MBW_TEST);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, single outstanding write and read
  reg aw_held;
  reg w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  wire [31:0] wmask;
  wire [31:0] ctrl_rw_mask;
  wire [31:0] ctrl_next;

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign do_write = aw_held && w_held && !s_axi_bvalid_o;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  // bits 3..0 are bank-zero status and a hole
  assign ctrl_rw_mask = 32'hFFFFFFF0;
  assign ctrl_next = (ctrl & ~(wmask & ctrl_rw_mask)) | (w_data & wmask & ctrl_rw_mask);

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `MBW_RESP_OKAY;
      ctrl <= `MBW_CTRL_RESET;
      mode <= `MBW_MODE_RESET;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `MBW_RESP_OKAY;
        if ({aw_addr[31:2], 2'h0} == `MBW_CTRL_ADDR)
          ctrl <= ctrl_next;
        else if ({aw_addr[31:2], 2'h0} == `MBW_MODE_ADDR)
        begin
          // holes in the mode byte must read back zero
          if (w_strb[0])
            mode[7:0] <= w_data[7:0] & 8'h17;
          if (w_strb[1])
            mode[9:8] <= w_data[9:8];
        end
        else
          s_axi_bresp_o <= `MBW_RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  wire [31:0] ctrl_view;
  assign ctrl_view = {ctrl[31:4], 1'b0, boot_bank_width, byte_order};

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `MBW_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `MBW_RESP_OKAY;
      if ({s_axi_araddr_i[31:2], 2'h0} == `MBW_CTRL_ADDR)
        s_axi_rdata_o <= ctrl_view;
      else if ({s_axi_araddr_i[31:2], 2'h0} == `MBW_MODE_ADDR)
        s_axi_rdata_o <= {22'h000000, mode};
      else
      begin
        s_axi_rdata_o <= 32'h00000000;
        s_axi_rresp_o <= `MBW_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-bank field decode
  wire [1:0] bank_width [0:7];
  wire [7:0] bank_wait;
  wire [7:0] bank_style;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_bank
      if (g == 0)
      begin : g_boot
        assign bank_width[g] = boot_bank_width;
        assign bank_wait[g] = 1'b0;
        assign bank_style[g] = 1'b0;
      end
      else
      begin : g_soft
        assign bank_width[g] = ctrl[g*`MBW_BANK_STEP+`MBW_WIDTH_LSB+1:g*`MBW_BANK_STEP+`MBW_WIDTH_LSB];
        assign bank_wait[g] = ctrl[g*`MBW_BANK_STEP+`MBW_WAIT_BIT];
        assign bank_style[g] = ctrl[g*`MBW_BANK_STEP+`MBW_STYLE_BIT];
      end
    end
  endgenerate

  wire [7:0] bank_dynamic;
  assign bank_dynamic = {mode[`MBW_B7DYN_BIT], mode[`MBW_B6DYN_BIT], 6'h00};
  wire [7:0] bank_wait_ok;
  assign bank_wait_ok = bank_wait & ~bank_dynamic;

  assign access_width_o = bank_width[access_bank_i];
  // wait honoured only when the bank allows it
  assign wait_stretch_o = ext_wait_sync[1] & bank_wait_ok[access_bank_i];

  ////////////////////////////////////////////////////////////////////////
  // address routing and strobes, registered toward the pins
  wire [25:0] mapped_addr;
  wire [1:0] mapped_bank;

  mbw_addr_map u_map
  (
    .width_i(bank_width[access_bank_i]),
    .size_i(mode[`MBW_SIZE_LSB+2:`MBW_SIZE_LSB]),
    .four_bank_i(mode[`MBW_ORG_BIT]),
    .addr_i(access_addr_i),
    .mem_addr_o(mapped_addr),
    .sdram_bank_o(mapped_bank)
  );

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mem_addr_o <= 26'h0000000;
      sdram_bank_o <= 2'h0;
      write_byte_strobe_n_o <= 4'hF;
      byte_lane_enable_n_o <= 4'hF;
      output_enable_n_o <= 1'b1;
    end
    else
    begin
      mem_addr_o <= mapped_addr;
      sdram_bank_o <= mapped_bank;
      output_enable_n_o <= read_strobe_n_i;
      if (bank_style[access_bank_i])
      begin
        // strobe pins become upper/lower byte enables for reads and writes
        write_byte_strobe_n_o <= 4'hF;
        byte_lane_enable_n_o <= write_lanes_n_i & {4{read_strobe_n_i}};
      end
      else
      begin
        write_byte_strobe_n_o <= write_lanes_n_i;
        byte_lane_enable_n_o <= 4'hF;
      end
    end
  end
endmodule // mbw_top
`default_nettype wire

// [bench/mbw_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module mbw_monitor
(
  input wire clk_i,
  input wire reset_i,
  input wire s_axi_awready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire test_mode_o,
  input wire [2:0] access_bank_i,
  input wire [25:0] access_addr_i,
  input wire [3:0] write_lanes_n_i,
  input wire read_strobe_n_i,
  input wire [25:0] mem_addr_o,
  input wire [1:0] access_width_o,
  input wire wait_stretch_o,
  input wire [3:0] write_byte_strobe_n_o,
  input wire [3:0] byte_lane_enable_n_o
);
  default clocking mcb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
  aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("awready during bvalid");
  addr_shift_a: assert property (!$past(reset_i) |-> mem_addr_o ==
    ($past(access_addr_i) >> ($past(access_width_o) == 2'h3 ? 2'h0 : $past(access_width_o))))
    else $error("address shift");
  strobe_pick_a: assert property (!(&write_byte_strobe_n_o) |-> &byte_lane_enable_n_o
    && write_byte_strobe_n_o == $past(write_lanes_n_i))
    else $error("write strobe");
  lane_and_a: assert property (!(&byte_lane_enable_n_o) |-> byte_lane_enable_n_o ==
    ($past(write_lanes_n_i) & {4{$past(read_strobe_n_i)}}))
    else $error("byte enable");
  boot_nowait_a: assert property (wait_stretch_o |-> access_bank_i != 3'h0)
    else $error("bank zero stretched");
  boot_width_a: assert property (access_bank_i == 3'h0 |-> test_mode_o == (access_width_o == 2'h3))
    else $error("boot width");
  mode_hold_a: assert property (!$past(reset_i) |-> $stable(test_mode_o))
    else $error("test mode moved");
endmodule // mbw_monitor
bind mbw_top mbw_monitor mon (.clk_i, .reset_i, .s_axi_awready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .test_mode_o, .access_bank_i, .access_addr_i, .write_lanes_n_i, .read_strobe_n_i, .mem_addr_o,
  .access_width_o, .wait_stretch_o, .write_byte_strobe_n_o, .byte_lane_enable_n_o);
`default_nettype wire

// [bench/mbw_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
// slow memory holds wait while it is being read
module mbw_mem_model
(
  input wire clk_i,
  input wire slow_i,
  input wire output_enable_n_i,
  output var logic ext_wait_o
);
  always @(posedge clk_i)
    ext_wait_o <= slow_i && !output_enable_n_i;
endmodule // mbw_mem_model
`default_nettype wire

// [bench/mbw_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mbw_regs.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("ERROR %s %h %h", n, e, a); end end
module mbw_top_bench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, rd_n = 1'b1, slow = 1'b0;
  logic awr, wr_o, bv, arr, rv, tmode, stretch, oe_n, ext_w;
  logic [31:0] addr = 32'h0, wdat = 32'h0, rdata, d;
  logic [2:0] bank = 3'h0;
  logic [25:0] acc = 26'h2ABCDEF, maddr;
  logic [3:0] lanes = 4'hF, wbs, ble;
  logic [1:0] bresp, rresp, sbank, accw, rsp;
  logic [1:0] boot_sel = 2'h1;
  logic order_pin = 1'b1;
  int fail_count = 0, tests_run = 0;
  mbw_top dut
  (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(addr), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wdat), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v), .s_axi_wready_o(wr_o),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(b_r), .s_axi_araddr_i(addr),
    .s_axi_arvalid_i(ar_v), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(r_r), .boot_width_select_i(boot_sel), .byte_order_i(order_pin),
    .test_mode_o(tmode), .access_bank_i(bank), .access_addr_i(acc), .write_lanes_n_i(lanes),
    .read_strobe_n_i(rd_n), .ext_wait_i(ext_w), .mem_addr_o(maddr), .sdram_bank_o(sbank),
    .access_width_o(accw), .wait_stretch_o(stretch), .write_byte_strobe_n_o(wbs),
    .byte_lane_enable_n_o(ble), .output_enable_n_o(oe_n)
  );
  mbw_mem_model mem (.clk_i(clk_i), .slow_i(slow), .output_enable_n_i(oe_n), .ext_wait_o(ext_w));
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("tests %0d fails %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // readies sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input int late = 0);
    int n;
    logic ta, tw, tb, hb;
    @(posedge clk_i);
    addr <= a;
    wdat <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    // late > 0 keeps bready low for that many cycles of bvalid
    b_r <= (late == 0);
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_i);
      ta = awr;
      tw = wr_o;
      hb = bv;
      tb = bv && b_r;
      rsp = bresp;
      if (hb && !b_r && late > 0)
        late--;
      @(posedge clk_i);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
      if (hb && !tb && late == 0) b_r <= 1'b1;
      if (tb) break;
    end
    b_r <= 1'b0;
    if (n == 40) fail_count++;
    if (n == 40) close_out;
  endtask
  task automatic rd(input logic [31:0] a);
    int n;
    logic ta, tr;
    @(posedge clk_i);
    addr <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_i);
      ta = arr;
      tr = rv;
      d = rdata;
      rsp = rresp;
      @(posedge clk_i);
      if (ta) ar_v <= 1'b0;
      if (tr) break;
    end
    r_r <= 1'b0;
    if (n == 40) fail_count++;
    if (n == 40) close_out;
  endtask
  // four edges let the wait pin cross its synchroniser
  task automatic go(input logic [2:0] b, input logic [3:0] l, input logic s);
    @(posedge clk_i);
    bank <= b;
    lanes <= l;
    rd_n <= s;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset(input logic [1:0] sel, input logic order);
    boot_sel <= sel;
    order_pin <= order;
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`MBW_CTRL_ADDR);
    `CHK("order", order, d[0])
    `CHK("boot", sel, d[2:1])
    `CHK("clear", 29'h0, d[31:3])
    `CHK("test", (sel == `MBW_TEST), tmode)
    $display("t_reset done");
  endtask
  task automatic t_regs;
    wr(`MBW_CTRL_ADDR, 32'hFFFFFFFF);
    `CHK("okay", `MBW_RESP_OKAY, rsp)
    rd(`MBW_CTRL_ADDR);
    `CHK("ro", 32'hFFFFFFF3, d)
    wr(`MBW_CTRL_ADDR, 32'h00000010, 2);
    `CHK("late okay", `MBW_RESP_OKAY, rsp)
    rd(`MBW_CTRL_ADDR);
    `CHK("late wr", 32'h00000013, d)
    rd(32'h01C80010);
    `CHK("err", `MBW_RESP_SLVERR, rsp)
    `CHK("err data", 32'h0, d)
    $display("t_regs done");
  endtask
  task automatic t_width;
    logic [1:0] ew [4] = '{2'h1, 2'h1, 2'h2, 2'h0};
    wr(`MBW_CTRL_ADDR, 32'h210);
    for (int b = 0; b < 4; b++)
    begin
      go(b[2:0], 4'hF, 1'b1);
      `CHK("width", ew[b], accw)
      `CHK("addr", acc >> ew[b], maddr)
    end
    $display("t_width done");
  endtask
  task automatic t_sdram;
    for (int s = 0; s < 5; s++)
    begin
      wr(`MBW_MODE_ADDR, 32'(s));
      go(3'h6, 4'hF, 1'b1);
      `CHK("two bank", {1'b0, acc[20 + s]}, sbank)
    end
    for (int s = 2; s < 5; s++)
    begin
      wr(`MBW_MODE_ADDR, 32'h10 | 32'(s));
      go(3'h6, 4'hF, 1'b1);
      `CHK("four bank", acc[20 + s -: 2], sbank)
    end
    $display("t_sdram done");
  endtask
  task automatic t_wait;
    logic [9:0] md [7] = '{10'h0, 10'h0, 10'h0, 10'h100, 10'h100, 10'h200, 10'h200};
    logic [2:0] bk [7] = '{3'h1, 3'h2, 3'h0, 3'h6, 3'h7, 3'h7, 3'h6};
    logic [6:0] ex = 7'b1010001;
    wr(`MBW_CTRL_ADDR, 32'h44000040);
    slow <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      wr(`MBW_MODE_ADDR, {22'h0, md[i]});
      go(bk[i], 4'hF, 1'b0);
      `CHK("stretch", ex[i], stretch)
    end
    slow <= 1'b0;
    go(3'h1, 4'hF, 1'b0);
    `CHK("no wait", 1'b0, stretch)
    $display("t_wait done");
  endtask
  task automatic t_style;
    wr(`MBW_CTRL_ADDR, 32'h80);
    go(3'h1, 4'hA, 1'b0);
    `CHK("be rd", 4'h0, ble)
    `CHK("no wbe", 4'hF, wbs)
    `CHK("oe", 1'b0, oe_n)
    go(3'h1, 4'hA, 1'b1);
    `CHK("be wr", 4'hA, ble)
    `CHK("oe off", 1'b1, oe_n)
    go(3'h2, 4'h5, 1'b1);
    `CHK("wbe", 4'h5, wbs)
    `CHK("no be", 4'hF, ble)
    $display("t_style done");
  endtask
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  initial
  begin
    t_reset(`MBW_W16, 1'b1);
    t_regs;
    t_width;
    t_sdram;
    t_wait;
    t_style;
    t_reset(`MBW_TEST, 1'b0);
    close_out;
  end
endmodule // mbw_top_bench
`default_nettype wire
